// >>> logic/sas_adc_seq.sv
// Purpose: Sequencer for a 12-bit successive-approximation converter
// Assumes: Analog front end compares input against the trial code
// Notes:   Registers over AXI4-Lite; result read clears the done flag
//
// Function
// (RULE_01) Codes 0-15 select external inputs
// (RULE_02) Codes 26, 27 route temperature, bandgap
// (RULE_03) Reserved codes give undefined results
// (RULE_04) Four conversion clock sources selectable
// (RULE_05) Selected source divided by divide field
// (RULE_06) Alternate clock unusable in stop states
// (RULE_07) Counter overflow starts one hardware conversion
// (RULE_08) Trigger works in run, wait, shallow stop
// (RULE_09) Twelve-bit linear successive approximation
// (RULE_10) Right-justified 12, 10 or 8 bits
// (RULE_11) Single or continuous; single returns idle
// (RULE_12) Optional less-than or greater-equal compare
// (RULE_13) Done flag set, interrupt request from it
// (RULE_14) Software prepares slow clock before temperature
// (RULE_15) Converts in wait, shallow stop, local clock
// (RULE_16) All-ones channel powers down, stops continuous
// (RULE_17) Control write aborts, restarts unless all ones
// (RULE_18) Control write or result read clears flag
// (RULE_19) Trigger synchronised, ignored while converting
// (RULE_20) Active bit high from start to end
//
// Decided for this implementation: the address map and the AXI4-Lite register port.

`timescale 1ns/10ps
`default_nettype none

module sas_adc_seq #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hardware_trigger_input,
  input wire logic local_async_clock,
  input wire logic alternate_clock,
  input wire logic shallow_stop_state,
  input wire logic deep_stop_state,
  input wire logic afe_cmp_hi,
  output logic [4:0] afe_channel_q,
  output logic afe_ext_sel_q,
  output logic afe_temp_en_q,
  output logic afe_bandgap_en_q,
  output logic afe_ref_hi_q,
  output logic afe_ref_lo_q,
  output logic afe_power_q,
  output logic afe_sample_q,
  output logic [11:0] afe_dac_q,
  output logic conv_irq_q
);

  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} sas_state_e;

  sas_state_e state_q;
  logic aw_held_q, w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aien_q, cont_q, done_flag_q;
  logic [4:0] chan_q;
  logic hwt_q, cfe_q, cge_q, lsmp_q;
  logic [1:0] div_q, mode_q, src_q;
  logic [11:0] cv_q, res_q, sar_q;
  logic [3:0] bit_q;
  logic [4:0] cnt_q;
  logic [2:0] trig_s_q;
  logic trig_pend_q;
  logic tick;
  logic wr_en, sc1_wr, rd_go, rd_res;
  logic [31:0] sc1_rd, sc2_rd, cfg_rd, wd_sc1, wd_sc2, wd_cfg, wd_cv, rd_word;
  logic rd_hit, wr_hit;
  logic [4:0] smp_last;
  logic [11:0] kept, final_v, fmt_v;
  logic done, cmp_true, done_set, hw_go, trig_edge, start_sw;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  function automatic logic [11:0] fmt(input logic [11:0] v, input logic [1:0] m);
    case (m)
      sas_pkg::MODE_10: fmt = {2'h0, v[11:2]};
      sas_pkg::MODE_8: fmt = {4'h0, v[11:4]};
      default: fmt = v;
    endcase
  endfunction : fmt

  // ----------------------------------------
  // Conversion clock
  // ----------------------------------------
  sas_clk_div u_clk_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_sel(src_q),
    .div_sel(div_q),
    .local_async_clock(local_async_clock),
    .alternate_clock(alternate_clock),
    .shallow_stop_state(shallow_stop_state),
    .deep_stop_state(deep_stop_state),
    .tick_q(tick)
  );

  // ----------------------------------------
  // Register views
  // ----------------------------------------
  always_comb begin
    sc1_rd = 32'h0000_0000;
    sc1_rd[sas_pkg::SC1_DONE] = done_flag_q;
    sc1_rd[sas_pkg::SC1_AIEN] = aien_q;
    sc1_rd[sas_pkg::SC1_CONT] = cont_q;
    sc1_rd[4:0] = chan_q;
    sc2_rd = 32'h0000_0000;
    // (RULE_20) Active bit shows state
    sc2_rd[sas_pkg::SC2_ACT] = (state_q != ST_IDLE);
    sc2_rd[sas_pkg::SC2_HWT] = hwt_q;
    sc2_rd[sas_pkg::SC2_CFE] = cfe_q;
    sc2_rd[sas_pkg::SC2_CGE] = cge_q;
    cfg_rd = 32'h0000_0000;
    cfg_rd[sas_pkg::CFG_DIV +: 2] = div_q;
    cfg_rd[sas_pkg::CFG_LSMP] = lsmp_q;
    cfg_rd[sas_pkg::CFG_MODE +: 2] = mode_q;
    cfg_rd[sas_pkg::CFG_SRC +: 2] = src_q;
  end

  assign wd_sc1 = merge(sc1_rd, wdata_q, wstrb_q);
  assign wd_sc2 = merge(sc2_rd, wdata_q, wstrb_q);
  assign wd_cfg = merge(cfg_rd, wdata_q, wstrb_q);
  assign wd_cv = merge({20'h0_0000, cv_q}, wdata_q, wstrb_q);

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign wr_en = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_hit = (awaddr_q == sas_pkg::OFF_SC1) || (awaddr_q == sas_pkg::OFF_SC2) ||
                  (awaddr_q == sas_pkg::OFF_RES) || (awaddr_q == sas_pkg::OFF_CMPV) ||
                  (awaddr_q == sas_pkg::OFF_CFG);
  assign sc1_wr = wr_en && (awaddr_q == sas_pkg::OFF_SC1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sas_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? sas_pkg::RESP_OKAY : sas_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aien_q <= 1'b0;
      cont_q <= 1'b0;
      chan_q <= sas_pkg::RST_CHAN;
      hwt_q <= 1'b0;
      cfe_q <= 1'b0;
      cge_q <= 1'b0;
      div_q <= 2'h0;
      lsmp_q <= 1'b0;
      mode_q <= sas_pkg::RST_MODE;
      src_q <= sas_pkg::SRC_BUS;
      cv_q <= 12'h000;
    end else if (wr_en) begin
      if (sc1_wr) begin
        aien_q <= wd_sc1[sas_pkg::SC1_AIEN];
        cont_q <= wd_sc1[sas_pkg::SC1_CONT];
        chan_q <= wd_sc1[4:0];
      end
      if (awaddr_q == sas_pkg::OFF_SC2) begin
        hwt_q <= wd_sc2[sas_pkg::SC2_HWT];
        cfe_q <= wd_sc2[sas_pkg::SC2_CFE];
        cge_q <= wd_sc2[sas_pkg::SC2_CGE];
      end
      if (awaddr_q == sas_pkg::OFF_CFG) begin
        div_q <= wd_cfg[sas_pkg::CFG_DIV +: 2];
        lsmp_q <= wd_cfg[sas_pkg::CFG_LSMP];
        mode_q <= wd_cfg[sas_pkg::CFG_MODE +: 2];
        src_q <= wd_cfg[sas_pkg::CFG_SRC +: 2];
      end
      if (awaddr_q == sas_pkg::OFF_CMPV) begin
        cv_q <= wd_cv[11:0];
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_res = rd_go && (s_axi_araddr[7:0] == sas_pkg::OFF_RES);

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr[7:0])
      sas_pkg::OFF_SC1: rd_word = sc1_rd;
      sas_pkg::OFF_SC2: rd_word = sc2_rd;
      sas_pkg::OFF_RES: rd_word = {20'h0_0000, res_q};
      sas_pkg::OFF_CMPV: rd_word = {20'h0_0000, cv_q};
      sas_pkg::OFF_CFG: rd_word = cfg_rd;
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sas_pkg::RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? sas_pkg::RESP_OKAY : sas_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Hardware trigger
  // ----------------------------------------
  assign trig_edge = trig_s_q[1] & ~trig_s_q[2];
  // (RULE_08) Deep stop blocks the trigger
  assign hw_go = trig_pend_q && tick && (state_q == ST_IDLE) && hwt_q &&
                 (chan_q != sas_pkg::CH_OFF) && !deep_stop_state && !sc1_wr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_s_q <= 3'h0;
      trig_pend_q <= 1'b0;
    end else begin
      trig_s_q <= {trig_s_q[1:0], hardware_trigger_input};
      // (RULE_19) Sync, ignore while active
      if (hw_go || sc1_wr || !hwt_q) begin
        trig_pend_q <= 1'b0;
      end else if (trig_edge && (state_q == ST_IDLE) && !deep_stop_state) begin
        trig_pend_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Successive approximation
  // ----------------------------------------
  assign smp_last = (lsmp_q ? sas_pkg::LONG_SMP : sas_pkg::SHORT_SMP) - 5'h01;
  assign kept = sar_q | (afe_cmp_hi ? 12'(12'h001 << bit_q) : 12'h000);
  assign done = (state_q == ST_CONVERT) && tick && (bit_q == 4'h0) && !sc1_wr;
  assign final_v = kept;
  // (RULE_10) Right-justified format
  assign fmt_v = fmt(final_v, mode_q);
  // (RULE_12) Less-than or greater-equal
  assign cmp_true = cge_q ? (fmt_v >= cv_q) : (fmt_v < cv_q);
  assign done_set = done && (!cfe_q || cmp_true);
  // (RULE_17) Write starts unless all ones
  // Trigger select is the stored bit; the written word is control one only
  assign start_sw = (wd_sc1[4:0] != sas_pkg::CH_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      sar_q <= 12'h000;
      bit_q <= sas_pkg::MSB_BIT;
      cnt_q <= 5'h00;
      afe_dac_q <= 12'h000;
    end else if (sc1_wr) begin
      // (RULE_16) All ones aborts, no restart
      state_q <= (start_sw && !hwt_q) ? ST_SAMPLE : ST_IDLE;
      cnt_q <= 5'h00;
      sar_q <= 12'h000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // (RULE_07) Overflow starts a conversion
          if (hw_go) begin
            state_q <= ST_SAMPLE;
            cnt_q <= 5'h00;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (cnt_q >= smp_last) begin
              // (RULE_09) Start twelve-bit search
              state_q <= ST_CONVERT;
              bit_q <= sas_pkg::MSB_BIT;
              sar_q <= 12'h000;
              afe_dac_q <= 12'h800;
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            sar_q <= kept;
            if (bit_q == 4'h0) begin
              // (RULE_11) Continuous restarts, single idles
              state_q <= (cont_q && chan_q != sas_pkg::CH_OFF) ? ST_SAMPLE : ST_IDLE;
              cnt_q <= 5'h00;
            end else begin
              bit_q <= bit_q - 4'h1;
              afe_dac_q <= kept | 12'(12'h001 << (bit_q - 4'h1));
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Result and done flag
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag_q <= 1'b0;
      res_q <= 12'h000;
      conv_irq_q <= 1'b0;
    end else begin
      // (RULE_13) Set wins over clear
      if (done_set) begin
        done_flag_q <= 1'b1;
        res_q <= fmt_v;
      end else if (sc1_wr || rd_res) begin
        // (RULE_18) Write or result read clears
        done_flag_q <= 1'b0;
      end
      conv_irq_q <= done_flag_q & aien_q;
    end
  end

  // ----------------------------------------
  // Front end routing
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      afe_channel_q <= sas_pkg::RST_CHAN;
      afe_ext_sel_q <= 1'b0;
      afe_temp_en_q <= 1'b0;
      afe_bandgap_en_q <= 1'b0;
      afe_ref_hi_q <= 1'b0;
      afe_ref_lo_q <= 1'b0;
      afe_power_q <= 1'b0;
      afe_sample_q <= 1'b0;
    end else begin
      afe_channel_q <= chan_q;
      // (RULE_01) External inputs 0 to 15
      afe_ext_sel_q <= (chan_q <= sas_pkg::CH_EXT_MAX);
      // (RULE_02) Temperature and bandgap
      afe_temp_en_q <= (chan_q == sas_pkg::CH_TEMP);
      afe_bandgap_en_q <= (chan_q == sas_pkg::CH_BANDGAP);
      // (RULE_03) Reserved codes route nothing
      afe_ref_hi_q <= (chan_q == sas_pkg::CH_REF_HI);
      afe_ref_lo_q <= (chan_q == sas_pkg::CH_REF_LO);
      // (RULE_16) Powered only while converting
      afe_power_q <= (state_q != ST_IDLE) && (chan_q != sas_pkg::CH_OFF);
      afe_sample_q <= (state_q == ST_SAMPLE);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  done_set_a: assert property (done_set |=> done_flag_q) // RULE_13
    else $error("done flag not set");
  done_clear_a: assert property ((sc1_wr || rd_res) && !done_set |=> !done_flag_q) // RULE_18
    else $error("done flag not cleared");
  off_abort_a: assert property (sc1_wr && wd_sc1[4:0] == sas_pkg::CH_OFF
    |=> state_q == ST_IDLE ##1 state_q == ST_IDLE) // RULE_16
    else $error("all-ones channel did not stop");
  sw_start_a: assert property (sc1_wr && start_sw && !hwt_q |=> state_q == ST_SAMPLE) // RULE_17
    else $error("control write did not restart");
  single_idle_a: assert property (done && !cont_q |=> state_q == ST_IDLE) // RULE_11
    else $error("single conversion did not idle");
  hw_start_a: assert property (hw_go |=> state_q == ST_SAMPLE && afe_sample_q == 1'b0
    ##1 afe_sample_q) // RULE_07
    else $error("trigger did not start sampling");
  trig_ignore_a: assert property (state_q != ST_IDLE |-> !trig_pend_q) // RULE_19
    else $error("trigger pending while active");
  msb_first_a: assert property ($rose(state_q == ST_CONVERT) |-> bit_q == sas_pkg::MSB_BIT
    && afe_dac_q == 12'h800) // RULE_09
    else $error("search did not start at top bit");
  fmt_res_a: assert property (done && !cfe_q |=> res_q == $past(fmt_v)) // RULE_10
    else $error("result not stored formatted");
  cmp_block_a: assert property (done && cfe_q && !cmp_true && !done_flag_q |=> !done_flag_q) // RULE_12
    else $error("failed compare set the flag");

  single_done_c: cover property (done && !cont_q);
  hw_trigger_c: cover property (hw_go);
  cont_restart_c: cover property (done && cont_q ##1 state_q == ST_SAMPLE);
  cmp_fail_c: cover property (done && cfe_q && !cmp_true);

endmodule : sas_adc_seq

`default_nettype wire

// >>> logic/sas_clk_div.sv
// Purpose: Conversion clock tick from one of four sources, divided
// Assumes: Local and alternate clocks are slow against aclk
// Notes:   Produces a one-cycle tick per conversion clock period

`timescale 1ns/10ps
`default_nettype none

module sas_clk_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] src_sel,
  input wire logic [1:0] div_sel,
  input wire logic local_async_clock,
  input wire logic alternate_clock,
  input wire logic shallow_stop_state,
  input wire logic deep_stop_state,
  output logic tick_q
);

  logic [2:0] loc_s_q;
  logic [2:0] alt_s_q;
  logic half_q;
  logic [2:0] cnt_q;
  logic [2:0] lim;
  logic src_edge;
  logic loc_edge;
  logic alt_edge;

  // ----------------------------------------
  // Source edges
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loc_s_q <= 3'h0;
      alt_s_q <= 3'h0;
      half_q <= 1'b0;
    end else begin
      loc_s_q <= {loc_s_q[1:0], local_async_clock};
      alt_s_q <= {alt_s_q[1:0], alternate_clock};
      half_q <= ~half_q;
    end
  end

  assign loc_edge = loc_s_q[1] & ~loc_s_q[2];
  assign alt_edge = alt_s_q[1] & ~alt_s_q[2];

  // (RULE_04) Four source choice
  always_comb begin
    src_edge = 1'b0;
    case (src_sel)
      // (RULE_15) Local clock replaces bus clock
      sas_pkg::SRC_BUS: src_edge = shallow_stop_state ? loc_edge : 1'b1;
      sas_pkg::SRC_BUS2: src_edge = shallow_stop_state ? loc_edge : half_q;
      // (RULE_06) Alternate clock stops in stop
      sas_pkg::SRC_ALT: src_edge = alt_edge & ~shallow_stop_state & ~deep_stop_state;
      sas_pkg::SRC_LOCAL: src_edge = loc_edge;
      default: src_edge = 1'b0;
    endcase
    if (deep_stop_state) begin
      src_edge = 1'b0;
    end
  end

  // (RULE_05) Divide by 1, 2, 4 or 8
  always_comb begin
    case (div_sel)
      2'h0: lim = 3'h0;
      2'h1: lim = 3'h1;
      2'h2: lim = 3'h3;
      default: lim = 3'h7;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= src_edge && (cnt_q >= lim);
      if (src_edge) begin
        cnt_q <= (cnt_q >= lim) ? 3'h0 : cnt_q + 3'h1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  alt_stop_gate_a: assert property ((src_sel == sas_pkg::SRC_ALT) &&
    (shallow_stop_state || deep_stop_state) |=> !tick_q) // RULE_06
    else $error("alternate clock ticked during stop");
  deep_stop_gate_a: assert property (deep_stop_state |=> !tick_q) // RULE_15
    else $error("tick during deep stop");

endmodule : sas_clk_div

`default_nettype wire

// >>> logic/sas_pkg.sv
// Purpose: Shared constants for the SAR converter sequencer
// Assumes: 32-bit AXI4-Lite register bus, one register per aligned word
// Notes:   Offsets are byte addresses; counts are in conversion clock ticks

package sas_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_SC1 = 8'h00;
  localparam logic [7:0] OFF_SC2 = 8'h04;
  localparam logic [7:0] OFF_RES = 8'h08;
  localparam logic [7:0] OFF_CMPV = 8'h0C;
  localparam logic [7:0] OFF_CFG = 8'h10;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SC1_DONE = 7;
  localparam int SC1_AIEN = 6;
  localparam int SC1_CONT = 5;
  localparam int SC2_ACT = 7;
  localparam int SC2_HWT = 6;
  localparam int SC2_CFE = 5;
  localparam int SC2_CGE = 4;
  localparam int CFG_DIV = 5;
  localparam int CFG_LSMP = 4;
  localparam int CFG_MODE = 2;
  localparam int CFG_SRC = 0;

  // ----------------------------------------
  // Channel codes
  // ----------------------------------------
  localparam logic [4:0] CH_EXT_MAX = 5'h0F;
  localparam logic [4:0] CH_TEMP = 5'h1A;
  localparam logic [4:0] CH_BANDGAP = 5'h1B;
  localparam logic [4:0] CH_RSV = 5'h1C;
  localparam logic [4:0] CH_REF_HI = 5'h1D;
  localparam logic [4:0] CH_REF_LO = 5'h1E;
  localparam logic [4:0] CH_OFF = 5'h1F;

  // ----------------------------------------
  // Modes, sources, reset values, counts
  // ----------------------------------------
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_BUS2 = 2'h1;
  localparam logic [1:0] SRC_ALT = 2'h2;
  localparam logic [1:0] SRC_LOCAL = 2'h3;
  localparam logic [4:0] RST_CHAN = 5'h1F;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [4:0] SHORT_SMP = 5'h04;
  localparam logic [4:0] LONG_SMP = 5'h18;
  localparam logic [3:0] MSB_BIT = 4'hB;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sas_pkg

// >>> tb/sas_adc_seq_tb_top.sv
// Purpose: Self-checking bench for the SAR converter sequencer
// Assumes: Analog input is an ideal comparator against the trial code
// Notes:   Registers reached only through AXI4-Lite tasks
`timescale 1ns/10ps
`default_nettype none
module sas_adc_seq_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hardware_trigger_input = 1'b0;
  logic local_async_clock = 1'b0, alternate_clock = 1'b0;
  logic shallow_stop_state = 1'b0, deep_stop_state = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_v;
  logic [4:0] afe_channel_q;
  logic afe_ext_sel_q, afe_temp_en_q, afe_bandgap_en_q, afe_ref_hi_q, afe_ref_lo_q;
  logic afe_power_q, afe_sample_q, conv_irq_q;
  logic [11:0] afe_dac_q;
  logic [11:0] vin = 12'h000;
  logic [3:0] slow_q = 4'h0;
  wire logic afe_cmp_hi = (vin >= afe_dac_q);
  int error_cnt = 0;
  int total_checks = 0;

  always #5 aclk = ~aclk;
  // Slow sources kept as divided copies so stop-mode gating is visible
  always @(posedge aclk) begin
    slow_q <= slow_q + 4'h1;
    local_async_clock <= slow_q[1];
    alternate_clock <= slow_q[3];
  end

  sas_adc_seq #(.ADDR_W(8)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .hardware_trigger_input, .local_async_clock, .alternate_clock,
    .shallow_stop_state, .deep_stop_state, .afe_cmp_hi, .afe_channel_q,
    .afe_ext_sel_q, .afe_temp_en_q, .afe_bandgap_en_q, .afe_ref_hi_q,
    .afe_ref_lo_q, .afe_power_q, .afe_sample_q, .afe_dac_q, .conv_irq_q);

  // ----------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Polls the flag; a slow source with divide two needs over a thousand cycles
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rd(sas_pkg::OFF_SC1);
      n++;
    end while (!rd_v[7] && n < 1000);
  endtask : wait_done

  function automatic logic [31:0] fmt(input logic [1:0] m, input logic [11:0] v);
    if (m == sas_pkg::MODE_8) return {24'h0, v[11:4]};
    if (m == sas_pkg::MODE_10) return {22'h0, v[11:2]};
    return {20'h0, v};
  endfunction : fmt

  function automatic logic [4:0] dec(input logic [4:0] c);
    if (c <= sas_pkg::CH_EXT_MAX) return 5'h10;
    if (c == sas_pkg::CH_TEMP) return 5'h08;
    if (c == sas_pkg::CH_BANDGAP) return 5'h04;
    if (c == sas_pkg::CH_REF_HI) return 5'h02;
    if (c == sas_pkg::CH_REF_LO) return 5'h01;
    return 5'h00;
  endfunction : dec

  task automatic conv(input logic [31:0] cfg);
    logic [31:0] ch;
    ch = 32'($urandom_range(15));
    wr(sas_pkg::OFF_CFG, cfg);
    wr(sas_pkg::OFF_SC1, ch);
    rd(sas_pkg::OFF_SC2);
    chk("active", rd_v, 32'h80);
    wait_done();
    chk("done", 32'(rd_v[7]), 32'h1);
    rd(sas_pkg::OFF_RES);
    chk("result", rd_v, fmt(cfg[3:2], vin));
    rd(sas_pkg::OFF_SC1);
    chk("flag clear", rd_v, ch);
    rd(sas_pkg::OFF_SC2);
    chk("idle", rd_v, 32'h0);
  endtask : conv

  task automatic wrap_up();
    $display("Checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h5a2e2218));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(sas_pkg::OFF_SC1);
    chk("reset chan", rd_v, 32'h1F);
    rd(8'h20);
    chk("unmapped", {rd_v[29:0], rsp}, 32'(sas_pkg::RESP_SLVERR));
    // every format, source and a divide
    for (int i = 0; i < 8; i++) begin
      vin <= (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
      conv({25'h0, 1'(i >> 1), 1'(i >> 2), 1'(i), 2'(i), 2'(i >> 1)});
    end
    wr(sas_pkg::OFF_CFG, 32'h4);
    // both compare senses, true and false
    for (int k = 0; k < 4; k++) begin
      vin <= 12'h7A5;
      wr(sas_pkg::OFF_CMPV, 32'h7A5 + 32'(k % 2));
      wr(sas_pkg::OFF_SC2, (k < 2) ? 32'h30 : 32'h20);
      wr(sas_pkg::OFF_SC1, 32'h3);
      repeat (60) @(posedge aclk);
      rd(sas_pkg::OFF_SC1);
      chk("compare", 32'(rd_v[7]), 32'((k < 2) == (k % 2 == 0)));
    end
    wr(sas_pkg::OFF_SC2, 32'h0);
    wr(sas_pkg::OFF_SC1, 32'h25);
    repeat (60) @(posedge aclk);
    rd(sas_pkg::OFF_SC1);
    chk("continuous", rd_v, 32'hA5);
    chk("power on", 32'(afe_power_q), 32'h1);
    // all-ones code ends continuous, no restart
    wr(sas_pkg::OFF_SC1, 32'h3F);
    repeat (40) @(posedge aclk);
    rd(sas_pkg::OFF_SC2);
    chk("stopped", rd_v, 32'h0);
    chk("power off", 32'(afe_power_q), 32'h0);
    for (int c = 0; c < 32; c++) begin
      wr(sas_pkg::OFF_SC1, 32'(c));
      repeat (2) @(posedge aclk);
      chk("decode", {22'h0, afe_channel_q, afe_ext_sel_q, afe_temp_en_q, afe_bandgap_en_q,
        afe_ref_hi_q, afe_ref_lo_q}, {22'h0, 5'(c), dec(5'(c))});
    end
    wr(sas_pkg::OFF_SC2, 32'h40);
    wr(sas_pkg::OFF_SC1, 32'h47);
    repeat (20) @(posedge aclk);
    rd(sas_pkg::OFF_SC2);
    chk("no start", rd_v, 32'h40);
    hardware_trigger_input <= 1'b1;
    repeat (3) @(posedge aclk);
    hardware_trigger_input <= 1'b0;
    repeat (60) @(posedge aclk);
    chk("irq", 32'(conv_irq_q), 32'h1);
    rd(sas_pkg::OFF_RES);
    repeat (2) @(posedge aclk);
    chk("irq clear", 32'(conv_irq_q), 32'h0);
    // shallow stop runs on the local clock
    wr(sas_pkg::OFF_SC2, 32'h0);
    shallow_stop_state <= 1'b1;
    wr(sas_pkg::OFF_CFG, 32'h4);
    wr(sas_pkg::OFF_SC1, 32'h2);
    wait_done();
    chk("shallow", rd_v, 32'h82);
    shallow_stop_state <= 1'b0;
    // bandgap before temperature, long sample, slow clock
    wr(sas_pkg::OFF_CFG, 32'h17);
    for (int c = 27; c > 25; c--) begin
      wr(sas_pkg::OFF_SC1, 32'(c));
      wait_done();
      chk("sensor", rd_v, 32'h80 + 32'(c));
    end
    // alternate clock gives nothing in deep stop
    deep_stop_state <= 1'b1;
    wr(sas_pkg::OFF_CFG, 32'h6);
    wr(sas_pkg::OFF_SC1, 32'h2);
    repeat (400) @(posedge aclk);
    rd(sas_pkg::OFF_SC1);
    chk("deep stop", rd_v, 32'h02);
    deep_stop_state <= 1'b0;
    wrap_up();
  end

  initial begin
    repeat (90000) @(posedge aclk);
    error_cnt++;
    wrap_up();
  end
endmodule : sas_adc_seq_tb_top
`default_nettype wire
